// ### src/pmc_ctrl.sv
// operating-mode control of a 10/100 twisted-pair transceiver
// Overview of operation
// - gate100 zero keeps 100M modules on; one turns them off at 10M
// - gate10 zero keeps 10M modules on; one turns them off at 100M
// - source select alone picks pin or register bit as negotiation enable
// - negotiation settles on best mode common to both ends
// - 100M path: 4B/5B coding and scrambling of transmitted nibbles
// - 10M path: Manchester coding of transmitted nibbles
// - full duplex lets transmit and receive run together
// - 10M full duplex: no loopback, no SQE test
// - full duplex: carrier only on receive, collision held low
// - without link, crossover swaps transmit and receive pairs
// - crossover off by enable pin or register field
// - crossover independent, resolves before negotiation proceeds
// - crossover comes up enabled after reset
// - source select low is hardware mode, high is software mode
// - half duplex: carrier on tx or rx, collision on rx during tx
`timescale 1ns/1ns
`include "pmc_map.svh"
module pmc_ctrl #(
  parameter int XO_CYCLES = `PMC_XO_INTERVAL_US * `PMC_CLK_MHZ
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire pmc_pkg::pmc_addr_t paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              config_source_select,
  input  wire logic              negotiation_select_pin,
  input  wire logic              crossover_auto_enable_pin,
  input  wire logic              link_detect,
  input  wire logic              rx_active,
  input  wire pmc_pkg::pmc_cap_t partner_cap,
  input  wire logic              tx_en,
  input  wire pmc_pkg::pmc_nib_t tx_data,
  output logic                   tx_ready,
  output logic      [7:0]        line_code,
  output logic                   line_valid,
  output logic                   line_manch,
  input  wire logic              line_ready,
  output logic                   speed100,
  output logic                   full_duplex,
  output logic                   mod100_enable,
  output logic                   mod10_enable,
  output logic                   mdix_swap,
  output logic                   crs,
  output logic                   col,
  output logic                   loop_enable,
  output logic                   sqe_enable
);
  import pmc_pkg::*;

  localparam int NSYNC = 9;
  localparam int XO_W  = $clog2(XO_CYCLES + 1);

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic             cfg_s;
  logic             nsel_s;
  logic             xo_pin_s;
  logic             link_s;
  logic             rx_s;
  pmc_cap_t         cap_s;
  logic             ctrl_an;
  logic             ctrl_speed;
  logic             ctrl_fd;
  logic             gate100;
  logic             gate10;
  logic [1:0]       xo_field;
  logic             rd_err;
  logic             wr_stb;
  logic [31:0]      stat_word;
  logic             an_en;
  logic             xo_en;
  pmc_xo_e          xo_state;
  logic [XO_W-1:0]  xo_timer;
  pmc_an_e          an_state;
  pmc_cap_t         common;
  logic             fifo_valid;
  logic             fifo_full;
  pmc_nib_t         fifo_data;
  logic             consume;
  logic [10:0]      scr;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign sync_in = {partner_cap, rx_active, link_detect,
                    crossover_auto_enable_pin, negotiation_select_pin,
                    config_source_select};

  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end
      else
      begin
        sync_a[i] <= sync_in[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  assign cfg_s    = sync_b[0];
  assign nsel_s   = sync_b[1];
  assign xo_pin_s = sync_b[2];
  assign link_s   = sync_b[3];
  assign rx_s     = sync_b[4];
  assign cap_s    = sync_b[8:5];

  //////////////////////////////////////////////////////////////////////
  // apb register file

  assign pready  = 1'b1;
  assign pslverr = rd_err && psel && penable;
  assign wr_stb  = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_an    <= `PMC_CTRL_AN_RST;
      ctrl_speed <= `PMC_CTRL_SPD_RST;
      ctrl_fd    <= `PMC_CTRL_FD_RST;
    end
    else if (wr_stb && paddr == `PMC_ADDR_CTRL)
    begin
      ctrl_an    <= pwdata[`PMC_CTRL_AN];
      ctrl_speed <= pwdata[`PMC_CTRL_SPEED];
      ctrl_fd    <= pwdata[`PMC_CTRL_DUPLEX];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate100  <= `PMC_EXT_GATE_RST;
      gate10   <= `PMC_EXT_GATE_RST;
      xo_field <= `PMC_EXT_XO_RST;
    end
    else if (wr_stb && paddr == `PMC_ADDR_EXT)
    begin
      gate100  <= pwdata[`PMC_EXT_GATE100];
      gate10   <= pwdata[`PMC_EXT_GATE10];
      xo_field <= pwdata[`PMC_EXT_XO_HI:`PMC_EXT_XO_LO];
    end
  end

  always_comb
  begin
    stat_word                     = '0;
    stat_word[`PMC_ST_LINK]       = link_s;
    stat_word[`PMC_ST_SPEED]      = speed100;
    stat_word[`PMC_ST_DUPLEX]     = full_duplex;
    stat_word[`PMC_ST_MDIX]       = mdix_swap;
    stat_word[`PMC_ST_AN_DONE]    = (an_state == AN_RESOLVED);
    stat_word[`PMC_ST_MOD100]     = mod100_enable;
    stat_word[`PMC_ST_MOD10]      = mod10_enable;
    stat_word[`PMC_ST_XO_LOCK]    = (xo_state == XO_LOCKED);
    stat_word[`PMC_ST_FIFO_FULL]  = fifo_full;
  end

  // read data captured in the setup phase, so no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      rd_err <= 1'b0;
    end
    else if (psel && !penable)
    begin
      rd_err <= 1'b0;
      if (paddr == `PMC_ADDR_CTRL)
      begin
        prdata                   <= '0;
        prdata[`PMC_CTRL_AN]     <= ctrl_an;
        prdata[`PMC_CTRL_SPEED]  <= ctrl_speed;
        prdata[`PMC_CTRL_DUPLEX] <= ctrl_fd;
      end
      else if (paddr == `PMC_ADDR_EXT)
      begin
        prdata                                <= '0;
        prdata[`PMC_EXT_GATE100]              <= gate100;
        prdata[`PMC_EXT_GATE10]               <= gate10;
        prdata[`PMC_EXT_XO_HI:`PMC_EXT_XO_LO] <= xo_field;
      end
      else if (paddr == `PMC_ADDR_STAT)
        prdata <= stat_word;
      else
      begin
        prdata <= '0;
        rd_err <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // crossover search

  assign xo_en = xo_pin_s && (xo_field == `PMC_XO_AUTO);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xo_state  <= XO_SEARCH;
      xo_timer  <= '0;
      mdix_swap <= 1'b0;
    end
    else if (!xo_en)
    begin
      xo_state  <= XO_OFF;
      xo_timer  <= '0;
      mdix_swap <= 1'b0;
    end
    else
    begin
      case (xo_state)
        XO_OFF:
        begin
          xo_state <= XO_SEARCH;
          xo_timer <= '0;
        end
        XO_SEARCH:
          if (link_s)
            xo_state <= XO_LOCKED;
          else if (xo_timer == XO_W'(XO_CYCLES - 1))
          begin
            xo_timer  <= '0;
            mdix_swap <= !mdix_swap;
          end
          else
            xo_timer <= xo_timer + XO_W'(1);
        default:
          if (!link_s)
          begin
            xo_state <= XO_SEARCH;
            xo_timer <= '0;
          end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // negotiation and operating mode

  assign an_en  = cfg_s ? ctrl_an : nsel_s;
  assign common = cap_s & `PMC_LOCAL_CAP;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      an_state    <= AN_IDLE;
      speed100    <= `PMC_CTRL_SPD_RST;
      full_duplex <= `PMC_CTRL_FD_RST;
    end
    else if (!an_en)
    begin
      an_state    <= AN_IDLE;
      speed100    <= ctrl_speed;
      full_duplex <= ctrl_fd;
    end
    else
    begin
      case (an_state)
        AN_IDLE:
          an_state <= AN_WAIT_XO;
        AN_WAIT_XO:
          if (link_s && xo_state != XO_SEARCH)
          begin
            an_state <= AN_RESOLVED;
            speed100    <= common[`PMC_CAP_100FD] || common[`PMC_CAP_100HD];
            full_duplex <= common[`PMC_CAP_100FD] ||
                           (!common[`PMC_CAP_100HD] && common[`PMC_CAP_10FD]);
          end
        default:
          if (!link_s)
            an_state <= AN_WAIT_XO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mod100_enable <= 1'b1;
      mod10_enable  <= 1'b1;
      loop_enable   <= 1'b0;
      sqe_enable    <= 1'b0;
      crs           <= 1'b0;
      col           <= 1'b0;
    end
    else
    begin
      mod100_enable <= speed100 || !gate100;
      mod10_enable  <= !speed100 || !gate10;
      loop_enable   <= !speed100 && !full_duplex;
      sqe_enable    <= !speed100 && !full_duplex;
      crs           <= full_duplex ? rx_s : (rx_s || tx_en);
      col           <= !full_duplex && rx_s && tx_en;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit coding path

  function automatic logic [4:0] pmc_enc5(input pmc_nib_t n);
    case (n)
      4'h0: pmc_enc5 = 5'h1e;
      4'h1: pmc_enc5 = 5'h09;
      4'h2: pmc_enc5 = 5'h14;
      4'h3: pmc_enc5 = 5'h15;
      4'h4: pmc_enc5 = 5'h0a;
      4'h5: pmc_enc5 = 5'h0b;
      4'h6: pmc_enc5 = 5'h0e;
      4'h7: pmc_enc5 = 5'h0f;
      4'h8: pmc_enc5 = 5'h12;
      4'h9: pmc_enc5 = 5'h13;
      4'ha: pmc_enc5 = 5'h16;
      4'hb: pmc_enc5 = 5'h17;
      4'hc: pmc_enc5 = 5'h1a;
      4'hd: pmc_enc5 = 5'h1b;
      4'he: pmc_enc5 = 5'h1c;
      default: pmc_enc5 = 5'h1d;
    endcase
  endfunction : pmc_enc5

  function automatic logic [7:0] pmc_manch(input pmc_nib_t n);
    pmc_manch = '0;
    for (int i = 0; i < 4; i++)
      pmc_manch[2*i +: 2] = {n[i], !n[i]};
  endfunction : pmc_manch

  pmc_fifo #(.WIDTH(`PMC_FIFO_WIDTH), .DEPTH(`PMC_FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_en),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (consume),
    .out_data  (fifo_data),
    .full      (fifo_full)
  );

  assign consume = fifo_valid && (!line_valid || line_ready);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_valid <= 1'b0;
      line_manch <= 1'b0;
      line_code  <= '0;
    end
    else if (consume)
    begin
      line_valid <= 1'b1;
      line_manch <= !speed100;
      if (speed100)
        line_code <= {3'h0, pmc_enc5(fifo_data) ^ scr[4:0]};
      else
        line_code <= pmc_manch(fifo_data);
    end
    else if (line_ready)
      line_valid <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scr <= `PMC_SCR_SEED;
    else if (consume && speed100)
      scr <= {scr[9:0], scr[10] ^ scr[8]};
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  gate100_off_a: assert property (!speed100 && gate100 |=> !mod100_enable)
    else $error("100M modules not gated at 10M");
  gate10_off_a: assert property (speed100 && gate10 |=> !mod10_enable)
    else $error("10M modules not gated at 100M");
  an_source_a: assert property (cfg_s && !ctrl_an |=> an_state == AN_IDLE)
    else $error("register bit ignored in software mode");
  hw_mode_a: assert property (!cfg_s && !nsel_s |=> an_state == AN_IDLE)
    else $error("pin ignored in hardware mode");
  an_best_a: assert property (an_en && an_state == AN_WAIT_XO && link_s &&
    xo_state != XO_SEARCH && common[`PMC_CAP_100FD]
    |=> speed100 && full_duplex)
    else $error("best common mode not chosen");
  code_path_a: assert property (consume |=> line_valid &&
    line_manch == !$past(speed100))
    else $error("wrong coding path");
  fd10_loop_a: assert property (full_duplex && !speed100
    |=> !loop_enable && !sqe_enable)
    else $error("loopback or sqe on in 10M full duplex");
  fd_col_a: assert property (full_duplex |=> !col && crs == $past(rx_s))
    else $error("full duplex carrier or collision wrong");
  hd_col_a: assert property (!full_duplex && rx_s && tx_en |=> col && crs)
    else $error("half duplex collision missed");
  xo_off_a: assert property (!xo_pin_s |=> xo_state == XO_OFF
    && !mdix_swap)
    else $error("crossover not disabled");
  xo_hold_a: assert property (xo_en && xo_state == XO_LOCKED && link_s
    |=> $stable(mdix_swap))
    else $error("pair assignment moved with link");
  xo_first_a: assert property (an_state == AN_WAIT_XO &&
    xo_state == XO_SEARCH |=> an_state != AN_RESOLVED)
    else $error("negotiation ran before crossover");

  an_100fd_c: cover property (an_state == AN_RESOLVED && speed100
    && full_duplex);
  xo_swap_c: cover property (xo_state == XO_SEARCH && $rose(mdix_swap));
  fifo_full_c: cover property (fifo_full && tx_en);
  col_c: cover property (col);
endmodule : pmc_ctrl

// ### src/pmc_fifo.sv
// valid/ready fifo with an output stage fed from the storage array
`timescale 1ns/1ns
module pmc_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pull;

  assign full     = (count == CW'(DEPTH));
  assign in_ready = !full;
  assign push     = in_valid && in_ready;
  assign pull     = (count != '0) && (!out_valid || out_ready);

  pmc_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_ram (
    .pclk    (pclk),
    .wr_en   (push),
    .wr_addr (wr_ptr),
    .wr_data (in_data),
    .rd_en   (pull),
    .rd_addr (rd_ptr),
    .rd_data (out_data)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pull)
        rd_ptr <= rd_ptr + AW'(1);
      if (push && !pull)
        count <= count + CW'(1);
      else if (pull && !push)
        count <= count - CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_valid <= 1'b0;
    else if (pull)
      out_valid <= 1'b1;
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule : pmc_fifo

// ### src/pmc_map.svh
// register map, field positions, reset values and timing of mode control
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_ADDR_W        8
`define PMC_ADDR_CTRL     8'h00
`define PMC_ADDR_EXT      8'h04
`define PMC_ADDR_STAT     8'h08

`define PMC_CTRL_DUPLEX   8
`define PMC_CTRL_AN       12
`define PMC_CTRL_SPEED    13
`define PMC_CTRL_RESET    32'h0000_3100
`define PMC_CTRL_AN_RST   1'b1
`define PMC_CTRL_SPD_RST  1'b1
`define PMC_CTRL_FD_RST   1'b1

`define PMC_EXT_GATE100   0
`define PMC_EXT_GATE10    1
`define PMC_EXT_XO_LO     8
`define PMC_EXT_XO_HI     9
`define PMC_EXT_RESET     32'h0000_0000
`define PMC_EXT_GATE_RST  1'b0
`define PMC_EXT_XO_RST    2'h0
`define PMC_XO_AUTO       2'h0

`define PMC_ST_LINK       0
`define PMC_ST_SPEED      1
`define PMC_ST_DUPLEX     2
`define PMC_ST_MDIX       3
`define PMC_ST_AN_DONE    4
`define PMC_ST_MOD100     5
`define PMC_ST_MOD10      6
`define PMC_ST_XO_LOCK    7
`define PMC_ST_FIFO_FULL  8

`define PMC_CAP_100FD     3
`define PMC_CAP_100HD     2
`define PMC_CAP_10FD      1
`define PMC_LOCAL_CAP     4'hf

`define PMC_CLK_MHZ       20
`define PMC_XO_INTERVAL_US 1000
`define PMC_SCR_SEED      11'h7ff
`define PMC_FIFO_WIDTH    4
`define PMC_FIFO_DEPTH    16

`endif

// ### src/pmc_pkg.sv
// types shared by the mode control files
package pmc_pkg;
  typedef logic [3:0] pmc_nib_t;
  typedef logic [3:0] pmc_cap_t;
  typedef logic [7:0] pmc_addr_t;
  typedef enum logic [1:0] {XO_OFF, XO_SEARCH, XO_LOCKED} pmc_xo_e;
  typedef enum logic [1:0] {AN_IDLE, AN_WAIT_XO, AN_RESOLVED} pmc_an_e;
endpackage : pmc_pkg

// ### src/pmc_ram.sv
// small storage array with registered read data
`timescale 1ns/1ns
module pmc_ram #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : pmc_ram

// ### test/phy_mode_control_tb.sv
// self-checking bench of the operating-mode control block
`timescale 1ns/1ns
`include "pmc_map.svh"
module phy_mode_control_tb;
  import pmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  pmc_addr_t   paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        pready, pslverr, re, css, neg_pin, xo_pin, link, rx;
  pmc_cap_t    cap;
  logic        tx_en, tx_ready, line_valid, line_manch, line_ready;
  pmc_nib_t    tx_data;
  logic [7:0]  line_code;
  logic        speed100, full_duplex, mod100, mod10, mdix, crs, col;
  logic        loop_en, sqe_en, ok;
  int          n_mismatch, compares, c, cnt, got, i;

  pmc_ctrl #(.XO_CYCLES(16)) u_pmc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_source_select(css),
    .negotiation_select_pin(neg_pin), .crossover_auto_enable_pin(xo_pin),
    .link_detect(link), .rx_active(rx), .partner_cap(cap),
    .tx_en(tx_en), .tx_data(tx_data), .tx_ready(tx_ready),
    .line_code(line_code), .line_valid(line_valid),
    .line_manch(line_manch), .line_ready(line_ready),
    .speed100(speed100), .full_duplex(full_duplex),
    .mod100_enable(mod100), .mod10_enable(mod10), .mdix_swap(mdix),
    .crs(crs), .col(col), .loop_enable(loop_en), .sqe_enable(sqe_en));
  pmc_mac_model u_pmc_mac_model (
    .pclk(pclk), .tx_ready(tx_ready), .tx_en(tx_en), .tx_data(tx_data));

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input pmc_addr_t a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 50)
      n_mismatch++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input pmc_addr_t a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(8);
  endtask : wr
  // mode outputs {speed, duplex, mod100, mod10, loop, sqe}
  task modes(input logic [5:0] x);
    chk("modes", {speed100, full_duplex, mod100, mod10, loop_en, sqe_en}, x);
  endtask : modes
  task flips(input int n);
    logic p;
    c = 0;
    p = mdix;
    repeat (n)
    begin
      @(posedge pclk);
      if (mdix !== p)
        c++;
      p = mdix;
    end
  endtask : flips
  function automatic logic [7:0] man(input logic [3:0] n);
    int k;
    man = 8'h00;
    for (k = 0; k < 4; k++)
      man[2*k +: 2] = {n[k], ~n[k]};
  endfunction : man

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {css, neg_pin, link, rx, cap} = '0;
    xo_pin = 1'b1;
    line_ready = 1'b1;
    n_mismatch = 0;
    compares = 0;
    cyc(20);
    presetn <= 1'b1;
    cyc(4);
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0);
    chk("ctrl", rq, `PMC_CTRL_RESET);
    apb(1'b0, `PMC_ADDR_EXT, 32'h0);
    chk("ext", rq, `PMC_EXT_RESET);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", re, 1'b1);
    chk("unmapped data", rq, 32'h0);
    flips(64);
    chk("search", c, 4);
    xo_pin <= 1'b0;
    cyc(8);
    flips(40);
    chk("pin off", {c[30:0], mdix}, 32'h0);
    xo_pin <= 1'b1;
    wr(`PMC_ADDR_EXT, 32'h100);
    flips(40);
    chk("field off", {c[30:0], mdix}, 32'h0);
    wr(`PMC_ADDR_EXT, 32'h1);
    wr(`PMC_ADDR_CTRL, 32'h0);
    modes(6'b000111);
    rx <= 1'b1;
    u_pmc_mac_model.hold(1'b1);
    cyc(8);
    chk("half", {crs, col}, 2'b11);
    wr(`PMC_ADDR_EXT, 32'h0);
    modes(6'b001111);
    wr(`PMC_ADDR_CTRL, 32'h100);
    modes(6'b011100);
    chk("full rx", {crs, col}, 2'b10);
    rx <= 1'b0;
    cyc(8);
    chk("full tx", {crs, col}, 2'b00);
    u_pmc_mac_model.hold(1'b0);
    wr(`PMC_ADDR_EXT, 32'h2);
    wr(`PMC_ADDR_CTRL, 32'h2100);
    modes(6'b111000);
    wr(`PMC_ADDR_EXT, 32'h0);
    modes(6'b111100);
    // 10 half: fill with the line stalled, then drain
    wr(`PMC_ADDR_CTRL, 32'h0);
    cyc(20);
    line_ready <= 1'b0;
    cnt = 0;
    ok = 1'b1;
    while (ok && cnt < 40)
    begin
      u_pmc_mac_model.send(cnt[3:0], ok);
      if (ok)
        cnt++;
    end
    u_pmc_mac_model.hold(1'b0);
    chk("filled", {cnt >= 16, tx_ready}, 2'b10);
    apb(1'b0, `PMC_ADDR_STAT, 32'h0);
    chk("full flag", rq[`PMC_ST_FIFO_FULL], 1'b1);
    line_ready <= 1'b1;
    got = 0;
    for (i = 0; i < 400 && got < cnt; i++)
    begin
      @(posedge pclk);
      if (line_valid === 1'b1)
      begin
        chk("manch", {line_manch, line_code}, {1'b1, man(got[3:0])});
        got++;
      end
    end
    chk("drained", got, cnt);
    wr(`PMC_ADDR_CTRL, 32'h2000);
    u_pmc_mac_model.send(4'h5, ok);
    u_pmc_mac_model.hold(1'b0);
    for (i = 0; i < 40 && line_valid !== 1'b1; i++)
      @(posedge pclk);
    // first 100M word: code 0b of nibble 5 xor unstepped seed bits 1f
    chk("100 word", {line_manch, line_code}, 9'h014);
    // software mode negotiation against a 10 full partner
    wr(`PMC_ADDR_CTRL, 32'h3000);
    cap <= 4'b0011;
    link <= 1'b1;
    css <= 1'b1;
    cyc(40);
    modes(6'b011100);
    apb(1'b0, `PMC_ADDR_STAT, 32'h0);
    chk("resolved", {rq[`PMC_ST_XO_LOCK], rq[`PMC_ST_AN_DONE]}, 2'b11);
    flips(40);
    chk("locked", c, 0);
    css <= 1'b0;
    cyc(10);
    modes(6'b101100);
    neg_pin <= 1'b1;
    cyc(20);
    modes(6'b011100);
    give_verdict();
  end

  initial
  begin
    cyc(20000);
    n_mismatch++;
    give_verdict();
  end
endmodule : phy_mode_control_tb

// ### test/pmc_mac_model.sv
// mac-side transmit source for the mode control bench
`timescale 1ns/1ns
module pmc_mac_model (
  input  wire logic        pclk,
  input  wire logic        tx_ready,
  output logic             tx_en,
  output pmc_pkg::pmc_nib_t tx_data
);
  import pmc_pkg::*;
  initial
  begin
    tx_en = 1'b0;
    tx_data = 4'h0;
  end
  // offer one nibble and hold it; give up after eight refused edges
  task send(input pmc_nib_t n, output logic ok);
    int i;
    tx_en <= 1'b1;
    tx_data <= n;
    ok = 1'b0;
    for (i = 0; i < 8 && !ok; i++)
    begin
      @(posedge pclk);
      ok = (tx_ready === 1'b1);
    end
  endtask : send
  // level drive; data is inverted on every call, idle or not
  task hold(input logic v);
    tx_en <= v;
    tx_data <= ~tx_data;
  endtask : hold
endmodule : pmc_mac_model
